// file: common/srp_cfg.svh
`ifndef SRP_CFG_SVH
`define SRP_CFG_SVH

// Opcodes of the register commands served by this bank
`define SRP_WRITE_STATUS_CMD 8'h01
`define SRP_WRITE_ANY_REG_CMD 8'h71
`define SRP_WRITE_DISABLE_CMD 8'h04
`define SRP_SPECIAL_SECTOR_WRITE_CMD 8'h42
`define SRP_SERIAL_NUMBER_WRITE_CMD 8'hc2
`define SRP_WRITE_ENABLE_CMD 8'h06
`define SRP_READ_STATUS_ONE_CMD 8'h05
`define SRP_READ_STATUS_TWO_CMD 8'h07
`define SRP_READ_ANY_REG_CMD 8'h65

// Register addresses used with the any-register commands
`define SRP_ADDR_STATUS_NV 24'h000000
`define SRP_ADDR_STATUS_V 24'h070000
`define SRP_ADDR_CRC_NV 24'h000001
`define SRP_ADDR_CRC_V 24'h070001

// Field positions of the first status register
`define SRP_LOCK_BIT 7
`define SRP_RSVD_BIT 6
`define SRP_ORIGIN_BIT 5
`define SRP_BP_HI 4
`define SRP_BP_LO 2
`define SRP_WEL_BIT 1
`define SRP_BUSY_BIT 0
// Bits that a register write may change
`define SRP_WRITABLE_MASK 8'hbc
`define SRP_STATUS_RESET 8'h00

// Field positions of the CRC status register
`define SRP_CRC_SUSPEND_BIT 4
`define SRP_CRC_ABORT_BIT 3

// Serial framing
`define SRP_BIT_LAST 3'h7
`define SRP_ADDR_LAST 2'h2

// Synchronised pin vector: positions and idle levels
`define SRP_PIN_W 5
`define SRP_PIN_SCK 0
`define SRP_PIN_CS_N 1
`define SRP_PIN_SI 2
`define SRP_PIN_WP_N 3
`define SRP_PIN_HWRST_N 4
`define SRP_PIN_IDLE 5'h1a

`endif

// file: common/srp_pkg.sv
package srp_pkg;

  // Phase of the serial frame
  typedef enum logic [2:0] {
    st_opcode,
    st_addr,
    st_data,
    st_read,
    st_ignore
  } srp_phase_e;

  // Source of the byte shifted out on a read
  typedef enum logic [1:0] {
    rd_status_one,
    rd_crc_status,
    rd_zero
  } srp_rdsel_e;

endpackage

// file: hdl/srp_pin_sync.sv
`timescale 1ns/1ps
`include "srp_cfg.svh"

module srp_pin_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Raw pins
  input wire logic [`SRP_PIN_W-1:0] i_pins,
  // Filtered pins
  output logic [`SRP_PIN_W-1:0] o_pins
);

  ////////////////////////////////////////////////////////////////////////
  // Three-stage chain per pin; the filtered level only moves once the
  // second and third stages agree, which rejects one-cycle glitches.
  genvar gi;
  generate
    for (gi = 0; gi < `SRP_PIN_W; gi = gi + 1) begin : g_pin
      // Idle levels as a vector, so one bit is picked, not truncated
      localparam logic [`SRP_PIN_W-1:0] idle_vec = `SRP_PIN_IDLE;
      logic q1;
      logic q2;
      logic q3;
      // Chain and filter share one process, all reset to idle
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          q1 <= idle_vec[gi];
          q2 <= idle_vec[gi];
          q3 <= idle_vec[gi];
          o_pins[gi] <= idle_vec[gi];
        end else begin
          q1 <= i_pins[gi];
          q2 <= q1;
          q3 <= q2;
          // First stage is read by the second stage only
          if (q2 == q3) begin
            o_pins[gi] <= q3;
          end
        end
      end
    end
  endgenerate

endmodule

// file: hdl/srp_bank.sv
`timescale 1ns/1ps
`include "srp_cfg.svh"

// Overview of operation
// R1 - Power-up and hardware reset reload working copy
// R2 - Control outputs come from working copy only
// R3 - Volatile write changes working copy, not shadow
// R4 - Nonvolatile write updates shadow and working copy
// R5 - Every status read returns the working copy
// R6 - CRC status register is read-only
// R7 - Status-one written and read by four commands
// R8 - Any-register write at zero is nonvolatile
// R9 - Any-register write at 0x070000 is volatile
// R10 - Any-register read at both addresses gives copy
// R11 - Eight bits, default zero, fixed bit layout
// R12 - Lock bit plus low protect pin blocks writes
// R13 - Locked register writes are ignored entirely; the latch still clears at deselect
// R14 - Lock bit zero never blocks register writes
// R15 - Origin bit one protects from array bottom
// R16 - Three block-protect bits select protected range
// R17 - Write latch read-only, volatile, resets to zero
// R18 - Busy bit read-only, one while busy
// R19 - Reserved bit always reads zero
// R20 - Only write-enable command sets the latch
// R21 - Listed write opcodes clear latch at deselect
// R22 - Busy set only during CRC calculation
// R23 - Writes never touch read-only or reserved bits

module srp_bank (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Serial pins from the host
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_write_protect_n,
  input wire logic i_hw_reset_n,
  // Serial data out, enable low while driving
  output logic o_so,
  output logic o_so_oe_n,
  // CRC engine state, same clock
  input wire logic i_crc_busy,
  input wire logic i_crc_suspended,
  input wire logic i_crc_aborted,
  // Protection settings for the array logic
  output logic o_protect_origin_sel,
  output logic [2:0] o_block_protect,
  output logic o_write_enable_latch,
  output logic o_reg_lock_active,
  output logic [7:0] o_status_reg_one
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  logic [`SRP_PIN_W-1:0] raw_pins; // Pins in vector order
  logic [`SRP_PIN_W-1:0] pins; // Filtered pins
  logic sck; // Filtered serial clock
  logic cs_n; // Filtered chip select
  logic si; // Filtered serial data in
  logic wp_n; // Filtered write-protect pin
  logic hwrst_n; // Filtered hardware reset pin

  assign raw_pins = {i_hw_reset_n, i_write_protect_n, i_si, i_cs_n, i_sck};

  srp_pin_sync u_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_pins(raw_pins),
    .o_pins(pins)
  );

  assign sck = pins[`SRP_PIN_SCK];
  assign cs_n = pins[`SRP_PIN_CS_N];
  assign si = pins[`SRP_PIN_SI];
  assign wp_n = pins[`SRP_PIN_WP_N];
  assign hwrst_n = pins[`SRP_PIN_HWRST_N];

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on the filtered pins

  logic sck_d; // Previous serial clock
  logic cs_n_d; // Previous chip select

  // Previous levels, idle after reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sck_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else begin
      sck_d <= sck;
      cs_n_d <= cs_n;
    end
  end

  logic sck_rise; // Input sampling edge inside a frame
  logic sck_fall; // Output shifting edge inside a frame
  logic cs_fall; // Frame start
  logic cs_rise; // Frame end, commit point

  // Mode 0 only: a clock edge counts while selected and out of reset
  assign sck_rise = sck & ~sck_d & ~cs_n & hwrst_n;
  assign sck_fall = ~sck & sck_d & ~cs_n & hwrst_n;
  assign cs_fall = ~cs_n & cs_n_d;
  assign cs_rise = cs_n & ~cs_n_d & hwrst_n;

  ////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0] shadow; // Nonvolatile copy, writable bits only
  logic [7:0] working; // Volatile copy, writable bits only
  logic write_enable_latch; // Write-enable latch
  logic reload_pend; // Working copy awaits the shadow

  logic [7:0] status_view; // Working copy as the host sees it
  logic [7:0] crc_view; // CRC status as the host sees it

  // Latch and busy live outside the stored bytes; reserved reads zero
  always_comb begin
    status_view = working & `SRP_WRITABLE_MASK; // [R5] [R11]
    status_view[`SRP_RSVD_BIT] = 1'b0; // [R19]
    status_view[`SRP_WEL_BIT] = write_enable_latch; // [R17]
    status_view[`SRP_BUSY_BIT] = i_crc_busy; // [R18] [R22]
  end

  // Only the two flag inputs reach this view; no write path exists
  always_comb begin
    crc_view = 8'h00; // [R6]
    crc_view[`SRP_CRC_SUSPEND_BIT] = i_crc_suspended;
    crc_view[`SRP_CRC_ABORT_BIT] = i_crc_aborted;
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame decoding state

  srp_pkg::srp_phase_e phase; // Frame phase
  srp_pkg::srp_rdsel_e rd_sel; // Read source
  logic [7:0] opcode; // Received opcode
  logic op_valid; // Opcode fully received
  logic [7:0] shift_in; // Input shift register
  logic [2:0] bit_cnt; // Bits of the current input byte
  logic [1:0] addr_cnt; // Address bytes received
  logic [23:0] addr; // Register address
  logic [7:0] data_byte; // First data byte of a write
  logic data_valid; // Data byte complete
  logic [7:0] out_sh; // Output shift register
  logic [2:0] out_cnt; // Bits already shifted out
  logic out_pend; // Next falling edge loads a byte

  logic byte_done; // Last bit of a byte on this edge
  logic [7:0] new_byte; // Byte completed on this edge
  logic [23:0] new_addr; // Address after this byte

  assign byte_done = sck_rise && (bit_cnt == `SRP_BIT_LAST);
  assign new_byte = {shift_in[6:0], si};
  assign new_addr = {addr[15:0], new_byte};

  ////////////////////////////////////////////////////////////////////////
  // Opcode and address decoding

  logic op_wr_status; // Status write opcode
  logic op_wr_any; // Any-register write opcode
  logic op_rd_any; // Any-register read opcode
  logic op_rd_one; // Status-one read opcode
  logic op_rd_two; // CRC status read opcode
  logic op_write_enable_cmd; // Write-enable opcode
  logic op_wel_clear; // Opcodes that drop the latch

  assign op_wr_status = (opcode == `SRP_WRITE_STATUS_CMD);
  assign op_wr_any = (opcode == `SRP_WRITE_ANY_REG_CMD);
  assign op_rd_any = (opcode == `SRP_READ_ANY_REG_CMD);
  assign op_rd_one = (new_byte == `SRP_READ_STATUS_ONE_CMD);
  assign op_rd_two = (new_byte == `SRP_READ_STATUS_TWO_CMD);
  assign op_write_enable_cmd = (opcode == `SRP_WRITE_ENABLE_CMD);
  // Memory write opcodes are deliberately absent from this list
  assign op_wel_clear = (opcode == `SRP_WRITE_DISABLE_CMD) ||
                        op_wr_status || op_wr_any ||
                        (opcode == `SRP_SPECIAL_SECTOR_WRITE_CMD) ||
                        (opcode == `SRP_SERIAL_NUMBER_WRITE_CMD); // [R21]

  srp_pkg::srp_rdsel_e addr_sel; // Read source for a full address

  // Both address aliases read the same working copy
  assign addr_sel =
    ((new_addr == `SRP_ADDR_STATUS_NV) ||
     (new_addr == `SRP_ADDR_STATUS_V)) ? srp_pkg::rd_status_one : // [R10]
    ((new_addr == `SRP_ADDR_CRC_NV) ||
     (new_addr == `SRP_ADDR_CRC_V)) ? srp_pkg::rd_crc_status :
    srp_pkg::rd_zero;

  logic [7:0] rd_value; // Byte loaded into the output shifter

  assign rd_value = (rd_sel == srp_pkg::rd_status_one) ? status_view :
                    (rd_sel == srp_pkg::rd_crc_status) ? crc_view :
                    8'h00; // [R5]

  ////////////////////////////////////////////////////////////////////////
  // Frame sequencer: inputs on rising edges, outputs on falling edges

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase <= srp_pkg::st_ignore;
      rd_sel <= srp_pkg::rd_zero;
      opcode <= 8'h00;
      op_valid <= 1'b0;
      shift_in <= 8'h00;
      bit_cnt <= 3'h0;
      addr_cnt <= 2'h0;
      addr <= 24'h000000;
      data_byte <= 8'h00;
      data_valid <= 1'b0;
      out_sh <= 8'h00;
      out_cnt <= 3'h0;
      out_pend <= 1'b0;
    end else if (!hwrst_n || cs_rise) begin
      // Frame over or aborted: stop driving; an abort also clears op_valid, other decode kept until next start
      phase <= srp_pkg::st_ignore;
      out_pend <= 1'b0;
      if (!hwrst_n) begin
        op_valid <= 1'b0;
      end
    end else if (cs_fall) begin
      // New frame always begins with an opcode
      phase <= srp_pkg::st_opcode;
      op_valid <= 1'b0;
      bit_cnt <= 3'h0;
      addr_cnt <= 2'h0;
      data_valid <= 1'b0;
      out_pend <= 1'b0;
    end else if (sck_rise) begin
      shift_in <= new_byte;
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done) begin
        case (phase)
          srp_pkg::st_opcode: begin
            opcode <= new_byte;
            op_valid <= 1'b1;
            if (new_byte == `SRP_WRITE_STATUS_CMD) begin
              phase <= srp_pkg::st_data; // [R7]
            end else if (new_byte == `SRP_WRITE_ANY_REG_CMD ||
                         new_byte == `SRP_READ_ANY_REG_CMD) begin
              phase <= srp_pkg::st_addr;
            end else if (op_rd_one || op_rd_two) begin
              phase <= srp_pkg::st_read; // [R7]
              out_pend <= 1'b1;
              rd_sel <= op_rd_one ? srp_pkg::rd_status_one :
                                    srp_pkg::rd_crc_status;
            end else begin
              phase <= srp_pkg::st_ignore;
            end
          end
          srp_pkg::st_addr: begin
            addr <= new_addr;
            addr_cnt <= addr_cnt + 2'h1;
            // Third address byte ends the address phase
            if (addr_cnt == `SRP_ADDR_LAST) begin
              if (op_wr_any) begin
                phase <= srp_pkg::st_data;
              end else begin
                phase <= srp_pkg::st_read;
                out_pend <= 1'b1;
                rd_sel <= addr_sel;
              end
            end
          end
          srp_pkg::st_data: begin
            // Only the first data byte counts; the rest is dropped
            data_byte <= new_byte;
            data_valid <= 1'b1;
            phase <= srp_pkg::st_ignore;
          end
          default: begin
            phase <= phase;
          end
        endcase
      end
    end else if (sck_fall && phase == srp_pkg::st_read) begin
      // Reload each byte so a polling host sees fresh status
      if (out_pend || out_cnt == `SRP_BIT_LAST) begin
        out_sh <= rd_value;
        out_cnt <= 3'h0;
        out_pend <= 1'b0;
      end else begin
        out_sh <= {out_sh[6:0], 1'b0};
        out_cnt <= out_cnt + 3'h1;
      end
    end
  end

  // Output pin: enable low only while a read byte is on the wire
  assign o_so = out_sh[7];
  assign o_so_oe_n = !(phase == srp_pkg::st_read && !out_pend && !cs_n);

  ////////////////////////////////////////////////////////////////////////
  // Write qualification at the end of a frame

  logic reg_locked; // Register writes blocked by lock and pin
  logic write_ok; // A register write may take effect
  logic wr_nv; // Shadow and working copy both written
  logic wr_v; // Working copy written
  logic [7:0] merged; // Host data limited to writable bits

  // Lock bit zero leaves the pin without any effect
  assign reg_locked = working[`SRP_LOCK_BIT] & ~wp_n; // [R12] [R14]
  // Busy also refuses writes, as the CRC engine owns the device then
  assign write_ok = cs_rise && op_valid && data_valid && write_enable_latch &&
                    !reg_locked && !i_crc_busy && !reload_pend; // [R13]
  assign wr_nv = write_ok && (op_wr_status ||
                 (op_wr_any && addr == `SRP_ADDR_STATUS_NV)); // [R4] [R8]
  assign wr_v = wr_nv || (write_ok && op_wr_any &&
                addr == `SRP_ADDR_STATUS_V); // [R3] [R9]
  assign merged = data_byte & `SRP_WRITABLE_MASK; // [R23]

  ////////////////////////////////////////////////////////////////////////
  // Shadow: cleared only by power-up, so it survives the reset pin

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shadow <= `SRP_STATUS_RESET; // [R11]
    end else if (wr_nv) begin
      shadow <= merged; // [R4]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Working copy: reloaded after power-up and on the reset pin

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      working <= `SRP_STATUS_RESET;
      reload_pend <= 1'b1;
    end else if (!hwrst_n) begin
      reload_pend <= 1'b1; // [R1]
    end else if (reload_pend) begin
      working <= shadow; // [R1]
      reload_pend <= 1'b0;
    end else if (wr_v) begin
      working <= merged; // [R3] [R4] [R23]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write-enable latch: set by one opcode, dropped by several

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      write_enable_latch <= 1'b0; // [R17]
    end else if (!hwrst_n) begin
      write_enable_latch <= 1'b0; // [R17]
    end else if (cs_rise && op_valid && op_write_enable_cmd && !i_crc_busy) begin
      write_enable_latch <= 1'b1; // [R20]
    end else if (cs_rise && op_valid && op_wel_clear) begin
      write_enable_latch <= 1'b0; // [R21]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Settings for the array logic: protection bits from the working copy, plus latch and status view

  // The array decoder reads the origin bit: one anchors the protected
  // range at the bottom of the array, zero at the top
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_protect_origin_sel <= 1'b0;
      o_block_protect <= 3'h0;
      o_write_enable_latch <= 1'b0;
      o_status_reg_one <= `SRP_STATUS_RESET;
    end else begin
      o_protect_origin_sel <= working[`SRP_ORIGIN_BIT]; // [R2] [R15]
      o_block_protect <= working[`SRP_BP_HI:`SRP_BP_LO]; // [R2] [R16]
      o_write_enable_latch <= write_enable_latch;
      o_status_reg_one <= status_view; // [R5]
    end
  end

  // Lock state for the configuration registers elsewhere in the device
  assign o_reg_lock_active = reg_locked; // [R12]

endmodule

// file: verification/srp_bank_checker.sv
`timescale 1ns/1ps

module srp_bank_checker (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Pins and engine state
  input wire logic i_cs_n,
  input wire logic i_write_protect_n,
  input wire logic i_hw_reset_n,
  input wire logic i_crc_busy,
  // Bank outputs
  input wire logic o_so_oe_n,
  input wire logic o_protect_origin_sel,
  input wire logic [2:0] o_block_protect,
  input wire logic o_write_enable_latch,
  input wire logic o_reg_lock_active,
  input wire logic [7:0] o_status_reg_one
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  ////////////////////////////////////////
  // Pin held low long enough to pass the three-flop filter
  sequence s_pin_low;
    !i_write_protect_n [*6];
  endsequence
  // Hardware reset pulse and its release
  sequence s_hw_pulse;
    !i_hw_reset_n [*6] ##1 i_hw_reset_n [*6];
  endsequence
  // Lock bit clear in two host views running, so the copy is clear too
  sequence s_lock_clear;
    !o_status_reg_one[7] ##1 !o_status_reg_one[7];
  endsequence

  // Host view lags the copy; compare only where it did not move
  a_lock_pin_low: assert property (
    s_pin_low |=> ($stable(o_status_reg_one) ->
      ($past(o_reg_lock_active) == o_status_reg_one[7])))
    else $error("lock flag disagrees with lock bit");
  a_lock_bit_zero: assert property (
    s_lock_clear |-> !$past(o_reg_lock_active))
    else $error("lock flag set with lock bit clear");
  a_reserved_zero: assert property (
    o_status_reg_one[6] == 1'b0)
    else $error("reserved bit reads one");
  a_busy_shown: assert property (
    i_crc_busy [*3] |-> o_status_reg_one[0])
    else $error("busy bit low during CRC work");
  a_busy_only_crc: assert property (
    !i_crc_busy [*3] |-> !o_status_reg_one[0])
    else $error("busy bit high without CRC work");
  a_copy_outputs: assert property (
    o_protect_origin_sel == o_status_reg_one[5] &&
    o_block_protect == o_status_reg_one[4:2])
    else $error("protection outputs differ from status view");
  a_wel_rise_idle: assert property (
    $rose(o_write_enable_latch) |-> i_cs_n)
    else $error("latch set inside a frame");
  a_wel_hw_reset: assert property (
    s_hw_pulse |-> !o_write_enable_latch)
    else $error("latch survives hardware reset");
  a_so_released: assert property (
    i_cs_n [*6] |-> o_so_oe_n)
    else $error("data out driven while deselected");
  a_status_idle: assert property (
    $changed(o_status_reg_one[7:2]) |-> i_cs_n)
    else $error("status changed inside a frame");
endmodule

bind srp_bank srp_bank_checker chk_u (
  .i_clk(i_clk),
  .i_arst_n(i_arst_n),
  .i_cs_n(i_cs_n),
  .i_write_protect_n(i_write_protect_n),
  .i_hw_reset_n(i_hw_reset_n),
  .i_crc_busy(i_crc_busy),
  .o_so_oe_n(o_so_oe_n),
  .o_protect_origin_sel(o_protect_origin_sel),
  .o_block_protect(o_block_protect),
  .o_write_enable_latch(o_write_enable_latch),
  .o_reg_lock_active(o_reg_lock_active),
  .o_status_reg_one(o_status_reg_one)
);

// file: verification/srp_host_model.sv
`timescale 1ns/1ps

module srp_host_model (
  // Bench clock, only to keep pin edges clear of it
  input wire logic i_clk,
  // Data returned by the bank
  input wire logic i_so,
  input wire logic i_so_oe_n,
  // Serial pins toward the bank
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si
);
  // Idle link: deselected, clock parked low for mode 0
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end

  ////////////////////////////////////////
  // One frame, MSB first; rx keeps the last eight bits seen
  // Clock runs only inside the frame, 125 ns period, own phase
  task automatic send(input logic [39:0] d, input int nbits,
                      output logic [7:0] rx);
    rx = 8'h00;
    // Start 1 ns after a falling edge: with 62.5 ns steps no pin edge
    // then lands on either edge of the system clock
    @(negedge i_clk);
    #1;
    o_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_si = d[39-i];
      #62.5;
      o_sck = 1'b1;
      // A released line reads as the inverse of the last bit
      rx = {rx[6:0], i_so_oe_n ? ~rx[0] : i_so};
      #62.5;
      o_sck = 1'b0;
    end
    #62.5;
    o_cs_n = 1'b1;
    // Toggle so a stale data bit is never mistaken for a driven one
    o_si = ~o_si;
    // Deselect gap covers filter, commit and status view lag
    #250;
  endtask
endmodule

// file: verification/status_reg_protect_bank_tb_top.sv
`timescale 1ns/1ps
`include "srp_cfg.svh"

module status_reg_protect_bank_tb_top;
  // Clock, reset, pins and engine state
  logic i_clk, i_arst_n, sck, cs_n, si, so, so_oe_n;
  logic wp_n, hw_rst_n, crc_busy, crc_susp, crc_abort;
  // Observed outputs
  logic origin, lock_act, write_enable_latch;
  logic [2:0] bp;
  logic [7:0] sr1, rx;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  // Opcodes that drop the latch at deselect
  logic [7:0] clr_ops [5] = '{`SRP_WRITE_DISABLE_CMD,
    `SRP_WRITE_STATUS_CMD, `SRP_SPECIAL_SECTOR_WRITE_CMD,
    `SRP_WRITE_ANY_REG_CMD, `SRP_SERIAL_NUMBER_WRITE_CMD};

  srp_bank dut_u (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_sck(sck),
    .i_cs_n(cs_n),
    .i_si(si),
    .i_write_protect_n(wp_n),
    .i_hw_reset_n(hw_rst_n),
    .o_so(so),
    .o_so_oe_n(so_oe_n),
    .i_crc_busy(crc_busy),
    .i_crc_suspended(crc_susp),
    .i_crc_aborted(crc_abort),
    .o_protect_origin_sel(origin),
    .o_block_protect(bp),
    .o_write_enable_latch(write_enable_latch),
    .o_reg_lock_active(lock_act),
    .o_status_reg_one(sr1)
  );

  srp_host_model host_u (
    .i_clk(i_clk),
    .i_so(so),
    .i_so_oe_n(so_oe_n),
    .o_sck(sck),
    .o_cs_n(cs_n),
    .o_si(si)
  );

  // System clock, 100 MHz
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Hang guard, well above the length of the sequence
  always @(posedge i_clk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      miscompares = miscompares + 1;
      conclude();
    end
  end

  ////////////////////////////////////////
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Level pins change off the sampling edge, then settle
  task automatic drive(input logic [3:0] v);
    @(negedge i_clk);
    {wp_n, crc_busy, crc_susp, crc_abort} = v;
    repeat (10) @(negedge i_clk);
  endtask

  task automatic hw_pulse();
    @(negedge i_clk);
    hw_rst_n = 1'b0;
    repeat (8) @(negedge i_clk);
    hw_rst_n = 1'b1;
    repeat (12) @(negedge i_clk);
  endtask

  task automatic write_enable_cmd();
    host_u.send({`SRP_WRITE_ENABLE_CMD, 32'h0}, 8, rx);
  endtask

  task automatic write_status_cmd(input logic [7:0] d);
    host_u.send({`SRP_WRITE_STATUS_CMD, d, 24'h0}, 16, rx);
  endtask

  task automatic write_any_reg_cmd(input logic [23:0] a, input logic [7:0] d);
    host_u.send({`SRP_WRITE_ANY_REG_CMD, a, d}, 40, rx);
  endtask

  task automatic read_any_reg_cmd(input logic [23:0] a, output logic [7:0] v);
    host_u.send({`SRP_READ_ANY_REG_CMD, a, 8'h00}, 40, v);
  endtask

  // All three read paths and the status port must agree
  task automatic chk_sr1(input logic [7:0] exp);
    host_u.send({`SRP_READ_STATUS_ONE_CMD, 32'h0}, 16, rx);
    chk("status_one_read", exp, rx);
    read_any_reg_cmd(`SRP_ADDR_STATUS_V, rx);
    chk("status_one_any_v", exp, rx);
    read_any_reg_cmd(`SRP_ADDR_STATUS_NV, rx);
    chk("status_one_any_nv", exp, rx);
    chk("status_port", exp, sr1);
  endtask

  ////////////////////////////////////////
  initial begin
    i_arst_n = 1'b0;
    hw_rst_n = 1'b1;
    {wp_n, crc_busy, crc_susp, crc_abort} = 4'h8;
    repeat (12) @(negedge i_clk);
    i_arst_n = 1'b1;
    repeat (12) @(negedge i_clk);
    // Factory default, and no write without the latch
    chk_sr1(8'h00);
    write_status_cmd(8'hbc);
    chk_sr1(8'h00);
    // Latch set only by write-enable, seen as bit 1
    write_enable_cmd();
    chk("latch", 8'h01, {7'h00, write_enable_latch});
    chk_sr1(8'h02);
    // Read-only and reserved bits ignore the data
    write_status_cmd(8'hff);
    chk_sr1(8'hbc);
    chk("origin_bp", 8'h0f, {4'h0, origin, bp});
    hw_pulse();
    chk_sr1(8'hbc);
    // Volatile write is lost at the next hardware reset
    write_enable_cmd();
    write_any_reg_cmd(`SRP_ADDR_STATUS_V, 8'hd7);
    chk_sr1(8'h94);
    hw_pulse();
    chk_sr1(8'hbc);
    // Lock bit set and pin low: write ignored, latch still drops
    drive(4'h0);
    chk("lock_active", 8'h01, {7'h00, lock_act});
    write_enable_cmd();
    write_any_reg_cmd(`SRP_ADDR_STATUS_NV, 8'h00);
    chk_sr1(8'hbc);
    // Pin high lifts the lock
    drive(4'h8);
    write_enable_cmd();
    write_status_cmd(8'h1c);
    chk_sr1(8'h1c);
    // Lock bit clear: pin low changes nothing
    drive(4'h0);
    chk("lock_idle", 8'h00, {7'h00, lock_act});
    write_enable_cmd();
    write_any_reg_cmd(`SRP_ADDR_STATUS_NV, 8'h20);
    hw_pulse();
    chk_sr1(8'h20);
    foreach (clr_ops[i]) begin
      write_enable_cmd();
      chk("latch_set", 8'h01, {7'h00, write_enable_latch});
      host_u.send({clr_ops[i], 32'h0}, 8, rx);
      chk("latch_clear", 8'h00, {7'h00, write_enable_latch});
    end
    // CRC status follows the engine and ignores writes
    drive(4'hb);
    write_enable_cmd();
    write_any_reg_cmd(`SRP_ADDR_CRC_V, 8'h00);
    host_u.send({`SRP_READ_STATUS_TWO_CMD, 32'h0}, 16, rx);
    chk("crc_status", 8'h18, rx);
    // One flag alone, so swapped bit positions show
    drive(4'h9);
    read_any_reg_cmd(`SRP_ADDR_CRC_NV, rx);
    chk("crc_abort", 8'h08, rx);
    // Busy shows as bit 0 and refuses write-enable and writes
    drive(4'hc);
    write_enable_cmd();
    chk("latch_busy", 8'h00, {7'h00, write_enable_latch});
    write_status_cmd(8'h00);
    chk_sr1(8'h21);
    drive(4'h8);
    chk_sr1(8'h20);
    // Power-up returns the shadow to its factory value
    @(negedge i_clk);
    i_arst_n = 1'b0;
    repeat (4) @(negedge i_clk);
    i_arst_n = 1'b1;
    repeat (12) @(negedge i_clk);
    chk_sr1(8'h00);
    conclude();
  end
endmodule
